// [rtl/dga_gain_control_interface.sv]
// Digital gain-control front end: parallel latch, 3-wire serial port,
// quick gain cut, power and performance controls.
// Assumes all pins are asynchronous to clk_sys_i and the serial clock is
// well below a quarter of the system clock rate.
// Behaviour
// RULE1: Select pin low takes gain from serial word, high from parallel pins.
// RULE2: Parallel mode gain word comes from the five gain-bit pins.
// RULE3: Hold pin low makes the parallel latch transparent, high holds it.
// RULE4: Transparent latch makes applied gain follow the pins continuously.
// RULE5: Holding latch keeps the captured gain, ignoring pin changes.
// RULE6: Serial port uses data pin, bit-four clock and bit-three select.
// RULE7: One eight-bit control word: read/write, two step bits, five gain.
// RULE8: Host writes with select low and exactly eight clock pulses.
// RULE9: Read bit high makes the device shift the word out on data.
// RULE10: After eight read clocks the port returns to write mode.
// RULE11: Quick cut lowers gain by a chosen step, not a new code.
// RULE12: Step bits 00,01,10,11 give 1,2,4,8 dB.
// RULE13: Serial mode bit-two pin high applies the step, low removes it.
// RULE14: Binary code 0 is 15 dB, each step down 1 dB, 21 is -6 dB.
// RULE15: Power-up pin high powers up, low powers down, in both modes.
// RULE16: Performance pin high selects low power, low high performance.
// RULE17: Shared pins route to parallel or serial use by select pin.
// RULE18: Frame is MSB first: read/write, steps, gain; sampled on rise.
// RULE19: Codes above the top code and deep cuts clamp at minimum gain.
// RULE20: Releasing the cut restores the stored gain without a new write.
`timescale 1ns/10ps
`include "dga_gain_defines.svh"

module dga_gain_control_interface
  import dga_gain_pkg::*;
(
  // System
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Mode and hold pins
  input wire logic interface_select_i,
  input wire logic hold_control_i,
  // Shared gain pins
  input wire logic gain_bit4_or_serial_clock_i,
  input wire logic gain_bit3_or_select_n_i,
  input wire logic gain_bit2_or_quick_cut_i,
  input wire logic gain_bit1_i,
  input wire logic gain_bit0_i,
  // Serial data pin
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  // Power pins
  input wire logic power_up_control_i,
  input wire logic performance_select_i,
  // Applied state
  output logic [`GAIN_W-1:0] gain_code_o,
  output logic signed [5:0] gain_db_o,
  output logic [7:0] control_word_o,
  output logic powered_up_o,
  output logic low_power_o
);

  localparam int NSYNC = 9;

  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic mode_par, hold, sclk, cs_n, b2, b1, b0, sdi, pwr, perf;
  logic sclk_prev_q;
  logic sclk_rise, sclk_fall;
  serial_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] word_q;
  gain_code_t latch_q;
  gain_code_t par_gain, base_gain, step, cut_gain, applied;
  logic [5:0] cut_sum;
  logic port_off, last_bit, read_req;

  // Two-stage synchronisers for every pin but the performance pin
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {interface_select_i, hold_control_i,
                 gain_bit4_or_serial_clock_i, gain_bit3_or_select_n_i,
                 gain_bit2_or_quick_cut_i, gain_bit1_i, gain_bit0_i,
                 serial_data_i, power_up_control_i};
      sync_q <= meta_q;
    end
  end

  assign mode_par = sync_q[8];
  assign hold = sync_q[7];
  assign sclk = sync_q[6]; // [RULE6]
  assign cs_n = sync_q[5];
  assign b2 = sync_q[4];
  assign b1 = sync_q[3];
  assign b0 = sync_q[2];
  assign sdi = sync_q[1];
  assign pwr = sync_q[0];

  // Performance pin has its own synchroniser pair
  logic perf_meta_q, perf_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      perf_meta_q <= 1'b0;
      perf_q <= 1'b0;
    end else begin
      perf_meta_q <= performance_select_i;
      perf_q <= perf_meta_q;
    end
  end
  assign perf = perf_q;

  // Serial clock edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk;
    end
  end
  assign sclk_rise = sclk & ~sclk_prev_q; // [RULE18]
  assign sclk_fall = ~sclk & sclk_prev_q;

  // Serial pins only act in serial mode with select low
  assign port_off = mode_par || cs_n; // [RULE17]
  assign last_bit = sclk_rise && (bit_cnt_q == 3'h7);
  // Read bit sits in shift_q[6] just before the eighth bit arrives
  assign read_req = (state_q == ST_SHIFT_IN) && shift_q[6]; // [RULE9]

  // Frame state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else if (port_off) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SHIFT_IN: begin
          if (last_bit) begin
            state_q <= read_req ? ST_SHIFT_OUT : ST_IDLE;
          end else if (sclk_rise) begin
            state_q <= ST_SHIFT_IN; // [RULE8]
          end
        end
        ST_SHIFT_OUT: begin
          if (last_bit) begin
            state_q <= ST_IDLE; // [RULE10]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter; a deselect aborts a frame with no partial write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= 3'h0;
    end else if (port_off) begin
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Shift register: bits in during a request, stored word out on a read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      shift_q <= 8'h00;
    end else if (!port_off && sclk_rise) begin
      if (state_q == ST_SHIFT_OUT) begin
        shift_q <= {shift_q[6:0], 1'b0};
      end else if (last_bit && read_req) begin
        shift_q <= word_q; // [RULE9]
      end else begin
        shift_q <= {shift_q[6:0], sdi}; // [RULE18]
      end
    end
  end

  // Stored control word, loaded at the eighth bit of a write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      word_q <= `WORD_RESET;
    end else if (!port_off && last_bit && !read_req &&
                 state_q != ST_SHIFT_OUT) begin
      word_q <= {shift_q[6:0], sdi}; // [RULE7]
    end
  end

  // Data pin enable: the device drives only during readout
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      serial_data_oe_o <= 1'b0;
    end else begin
      serial_data_oe_o <= (state_q == ST_SHIFT_OUT) && !port_off;
    end
  end

  // Data pin value changes while the serial clock is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      serial_data_o <= 1'b0;
    end else if (state_q == ST_SHIFT_OUT && (sclk_fall || !sclk)) begin
      serial_data_o <= shift_q[7]; // [RULE9]
    end else if (state_q != ST_SHIFT_OUT) begin
      serial_data_o <= 1'b0;
    end
  end

  // Parallel input latch
  assign par_gain = {sclk, cs_n, b2, b1, b0}; // [RULE2]
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      latch_q <= '0;
    end else if (!hold) begin // [RULE3]
      latch_q <= par_gain; // [RULE4]
    end
  end

  // Gain selection and quick cut
  always_comb begin
    unique case (word_q[`FRAME_STEP_HI:`FRAME_STEP_LO]) // [RULE12]
      `STEP_CODE_1DB: step = `STEP_1DB;
      `STEP_CODE_2DB: step = `STEP_2DB;
      `STEP_CODE_4DB: step = `STEP_4DB;
      `STEP_CODE_8DB: step = `STEP_8DB;
    endcase
  end

  // Gain source by mode; in parallel mode the held value is used while hold is high
  always_comb begin
    if (!mode_par) begin
      base_gain = word_q[`GAIN_W-1:0]; // [RULE1]
    end else if (hold) begin
      base_gain = latch_q; // [RULE5]
    end else begin
      base_gain = par_gain; // [RULE4]
    end
  end

  // Higher code means less gain, so a cut adds to the code [RULE11]
  assign cut_sum = {1'b0, base_gain} + {1'b0, step};

  // A cut past the top code stops at minimum gain
  always_comb begin
    if (cut_sum > {1'b0, `GAIN_CODE_MAX}) begin
      cut_gain = `GAIN_CODE_MAX; // [RULE19]
    end else begin
      cut_gain = cut_sum[`GAIN_W-1:0];
    end
  end

  always_comb begin
    if (!mode_par && b2) begin // [RULE13]
      applied = cut_gain;
    end else if (base_gain > `GAIN_CODE_MAX) begin
      applied = `GAIN_CODE_MAX; // [RULE19]
    end else begin
      applied = base_gain; // [RULE20]
    end
  end

  // Applied gain code
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gain_code_o <= '0;
    end else begin
      gain_code_o <= applied;
    end
  end

  // Applied gain in dB, from the same code in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gain_db_o <= `GAIN_DB_AT_ZERO;
    end else begin
      gain_db_o <= `GAIN_DB_AT_ZERO - $signed({1'b0, applied}); // [RULE14]
    end
  end

  // Stored control word
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      control_word_o <= `WORD_RESET;
    end else begin
      control_word_o <= word_q;
    end
  end

  // Power state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      powered_up_o <= 1'b0;
    end else begin
      powered_up_o <= pwr; // [RULE15]
    end
  end

  // Performance state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      low_power_o <= 1'b0;
    end else begin
      low_power_o <= perf; // [RULE16]
    end
  end

endmodule

// [rtl/dga_gain_defines.svh]
// Constants of the gain-control front end: frame layout, codes, step sizes.
// Assumes inclusion by bare name from the package and design file.
`ifndef DGA_GAIN_DEFINES_SVH
`define DGA_GAIN_DEFINES_SVH

`define FRAME_BITS 8
`define FRAME_RW_BIT 7
`define FRAME_STEP_HI 6
`define FRAME_STEP_LO 5
`define GAIN_W 5
`define GAIN_CODE_MAX 5'h15
`define GAIN_DB_AT_ZERO 6'sh0f
`define WORD_RESET 8'h00
`define STEP_CODE_1DB 2'h0
`define STEP_CODE_2DB 2'h1
`define STEP_CODE_4DB 2'h2
`define STEP_CODE_8DB 2'h3
`define STEP_1DB 5'h01
`define STEP_2DB 5'h02
`define STEP_4DB 5'h04
`define STEP_8DB 5'h08

`endif

// [rtl/dga_gain_pkg.sv]
// Types shared by the gain-control front end.
// Assumes the defines header sits beside it.
`include "dga_gain_defines.svh"

package dga_gain_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT_IN = 2'b01,
    ST_SHIFT_OUT = 2'b10
  } serial_state_e;
  typedef logic [`GAIN_W-1:0] gain_code_t;
endpackage

// [sim/dga_gain_control_interface_properties.sv]
// Checker of the gain front end, bound to its top module.
// Assumes pins stay steady for several clocks between changes.
`timescale 1ns/10ps
module dga_gain_props
  import dga_gain_pkg::*;
(
  // Watched ports
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic interface_select_i,
  input wire logic hold_control_i,
  input wire logic power_up_control_i,
  input wire logic performance_select_i,
  input wire logic serial_data_oe_o,
  input wire logic [4:0] gain_code_o,
  input wire logic signed [5:0] gain_db_o,
  input wire logic [7:0] control_word_o,
  input wire logic powered_up_o,
  input wire logic low_power_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_db_from_code: assert property (
    gain_db_o == 6'sd15 - $signed({1'b0, gain_code_o})) else $error("db");
  a_code_clamped: assert property (
    gain_code_o <= 5'h15) else $error("code above top");
  a_power_up: assert property (
    $rose(power_up_control_i) |-> ##[1:5] powered_up_o) else $error("up");
  a_power_down: assert property (
    $fell(power_up_control_i) |-> ##[1:5] !powered_up_o) else $error("dn");
  a_low_power_on: assert property (
    $rose(performance_select_i) |-> ##[1:5] low_power_o) else $error("lp");
  a_low_power_off: assert property (
    $fell(performance_select_i) |-> ##[1:5] !low_power_o) else $error("hp");
  a_hold_freezes: assert property (
    (interface_select_i && hold_control_i)[*6] |=> $stable(gain_code_o))
    else $error("held gain moved");
  a_par_word_kept: assert property (
    interface_select_i[*6] |=> $stable(control_word_o)) else $error("word");
  a_oe_serial_only: assert property (
    interface_select_i[*6] |-> !serial_data_oe_o) else $error("oe");
  c_read: cover property ($rose(serial_data_oe_o));
  c_hold: cover property (interface_select_i && hold_control_i);
  c_word: cover property ($changed(control_word_o));
endmodule

bind dga_gain_control_interface dga_gain_props u_props (.*);

// [sim/dga_host_model.sv]
// Host controller model driving the three-wire gain port.
// Assumes the bench routes its pins onto the shared gain pins.
`timescale 1ns/10ps
module dga_host_model (
  // Pins
  output logic sclk_o,
  output logic sel_n_o,
  output logic sd_o,
  input wire logic line_i
);
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sd_o = 1'b0;
  end
  // Read requests add eight readout clocks; the host keeps toggling sd_o then
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    int n;
    n = w[7] ? 16 : 8;
    r = 8'h00;
    sel_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sd_o = (i < 8) ? w[7-i] : ~sd_o;
      #96 sclk_o = 1'b1;
      if (i >= 8) r = {r[6:0], line_i};
      #64 sclk_o = 1'b0;
    end
    #96 sel_n_o = 1'b1;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench of the gain front end with a host model.
// Assumes the host model owns the serial pins in serial mode.
`timescale 1ns/10ps
module tb_top;
  import dga_gain_pkg::*;
  logic clk_sys_i, rst_n_i, sel, hold, pwr, pm, up, lp;
  logic sd_o, sd_oe, sclk, sel_n, hsd;
  logic [4:0] par, code;
  logic signed [5:0] db;
  logic [7:0] word, r;
  int error_cnt, checks_done;
  wire line = sd_oe ? sd_o : hsd;
  wire [4:0] pin = sel ? par : {sclk, sel_n, par[2:0]};
  dga_gain_control_interface uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .interface_select_i(sel), .hold_control_i(hold),
    .gain_bit4_or_serial_clock_i(pin[4]),
    .gain_bit3_or_select_n_i(pin[3]), .gain_bit2_or_quick_cut_i(pin[2]),
    .gain_bit1_i(pin[1]), .gain_bit0_i(pin[0]), .serial_data_i(line),
    .serial_data_o(sd_o), .serial_data_oe_o(sd_oe),
    .power_up_control_i(pwr), .performance_select_i(pm),
    .gain_code_o(code), .gain_db_o(db), .control_word_o(word),
    .powered_up_o(up), .low_power_o(lp));
  dga_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .sd_o(hsd),
    .line_i(line));
  function automatic int sat(int v);
    return v > 21 ? 21 : v;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic expect_gain(int c);
    repeat (10) @(negedge clk_sys_i);
    chk("gain", {3'h0, code}, 8'(c));
    chk("db", 8'(db), 8'(15 - c));
    chk("power", {7'h0, up}, {7'h0, pwr});
    chk("perf", {7'h0, lp}, {7'h0, pm});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    int g, w;
    error_cnt = 0;
    checks_done = 0;
    {rst_n_i, sel, hold, pwr, pm, par} = '0;
    void'($urandom(32'h9cf3));
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    expect_gain(0);
    chk("word", word, 8'h00);
    for (int i = 0; i < 8; i++) begin
      w = (i % 4) * 32 + $urandom % 32;
      pwr = 1'($urandom);
      pm = 1'($urandom);
      host.xfer(8'(w), r);
      expect_gain(sat(w % 32));
      chk("word", word, 8'(w));
      par[2] = 1'b1;
      expect_gain(sat(w % 32 + (1 << (i % 4))));
      par[2] = 1'b0;
      host.xfer(8'h80, r);
      expect_gain(sat(w % 32));
      chk("readback", r, 8'(w));
    end
    sel = 1'b1;
    for (int i = 0; i < 8; i++) begin
      g = $urandom % 32;
      par = 5'(g);
      hold = 1'b0;
      expect_gain(sat(g));
      hold = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      par = ~par;
      expect_gain(sat(g));
      chk("word", word, 8'(w));
    end
    {sel, hold, par} = '0;
    expect_gain(sat(w % 32));
    give_verdict();
  end
endmodule
